// ==== verilog/tasr_map.vh ====
`ifndef TASR_MAP_VH
`define TASR_MAP_VH

// =====================================================================
// Register indices; the APB byte address is four times the index.
`define TASR_STATUS_IDX   10'h012
`define TASR_MASK_IDX     10'h014
`define TASR_CONFIG_IDX   10'h010

// =====================================================================
// Status and mask bit positions, shared by both registers.
`define TASR_BIT_SIGLOSS  0
`define TASR_BIT_FRMLOSS  1
`define TASR_BIT_ALMIND   2
`define TASR_BIT_REMALM   3
`define TASR_BIT_IDLE     4
`define TASR_BIT_TXSOF    5
`define TASR_BIT_RXSOF    6
`define TASR_NUM_BITS     7

// =====================================================================
// Configuration register bit positions.
`define TASR_CFG_E3       0
`define TASR_CFG_CBIT     1
`define TASR_CFG_UNIPOLAR 2

// =====================================================================
// Reset values.
`define TASR_STATUS_RST   7'h00
`define TASR_MASK_RST     7'h00
`define TASR_CFG_RST      3'h0

// =====================================================================
// Detector counts.
`define TASR_F_ERR_LIMIT  5'h03
`define TASR_M_ERR_LIMIT  5'h02
`define TASR_X_RUN        3'h4
`define TASR_FIELD_RUN    11'h400

`endif

// ==== verilog/tasr_alarm_status_irq.v ====
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "tasr_map.vh"

// =====================================================================
// Overview.
// The block keeps seven latched status bits and seven mask enables.
// Five bits follow alarm conditions and two follow frame-start pulses.
// An alarm latch sets from its condition and is cleared by a status read.
// A condition that still holds sets the latch again in the same cycle.
// This is why a persisting alarm always survives the read that saw it.
// Frame-start latches follow the boundary pulses and clear on read unless a pulse arrives in the read cycle.
// Pending causes are kept apart from the status latches on purpose.
// An alarm that ends after a read must still raise a fresh request.
// The status latch alone cannot show that, so the change is remembered.
// The interrupt request is the OR of every pending and unmasked cause.
// The group enable from the master mask gates it as a whole.
// The request is registered so that the output comes from a flip-flop.
// It is built from next_pending, so it rises on the same edge that sets the pending latch.
// A configuration word selects E3 mode, C-bit parity and unipolar line.
// In E3 mode the T3 detectors are held cleared and unused.
// Their E3 counterparts arrive as ready-made levels from the framer.
// The idle condition has no meaning in E3 and is held at zero there.
// Software is still expected to ignore that bit in E3 mode.
// In unipolar mode loss of signal is undefined and is gated off.
// The C-bit mode adds a coded remote alarm to the T3 remote alarm.
// Every register access takes exactly one wait state.
// Unmapped or unaligned addresses answer with an error and no effect.
// Writes to the status word are accepted and silently ignored.
// All inputs come from logic on the same clock and need no synchroniser.
// A user must keep the framer on this clock, or add one outside.
// The long field runs use eleven-bit counters held in flip-flops.
// This trades area for a detector that needs no slower clock.

module tasr_alarm_status_irq (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        signalLossDetect,
    input  wire        fBitValid,
    input  wire        fBitError,
    input  wire        mBitValid,
    input  wire        mBitError,
    input  wire        syncAcquired,
    input  wire        multiframeValid,
    input  wire        xBit1,
    input  wire        xBit2,
    input  wire        feacRemoteAlarm,
    input  wire        fieldValid,
    input  wire [1:0]  fieldPatternOk,
    input  wire [1:0]  fieldCBitsZero,
    input  wire        e3FrameLoss,
    input  wire        e3AlarmInd,
    input  wire        e3RemoteAlarm,
    input  wire        txFrameBoundary,
    input  wire        rxFrameBoundary,
    input  wire        groupIrqEnable,
    output reg         txFrameStartPin,
    output reg         rxFrameStartPin,
    output reg         irqRequest
);

    // =================================================================
    // Storage.
    reg  [6:0]  statusLatch;
    reg  [6:0]  pending;
    reg  [6:0]  maskReg;
    reg  [2:0]  cfgReg;
    reg  [4:0]  alarmPrev;
    reg  [15:0] fHist;
    reg  [3:0]  mHist;
    reg         frameLossT3;
    reg  [2:0]  zeroRun;
    reg  [2:0]  oneRun;
    reg         remoteAlarmT3;
    reg  [31:0] rdMux;
    reg  [6:0]  next_status;
    reg  [6:0]  next_pending;
    reg  [15:0] next_fHist;
    reg  [3:0]  next_mHist;

    wire [1:0]  patternDet;
    wire [4:0]  alarmCond;
    wire [6:0]  setVec;
    wire [6:0]  causeVec;
    wire        e3Mode;
    wire        cbitMode;
    wire        unipolarMode;
    wire        addrOk;
    wire        hitStatus;
    wire        hitMask;
    wire        hitConfig;
    wire        accessStart;
    wire        statusRead;
    wire        writeDone;
    wire        frameLossDeclare;

    assign e3Mode       = cfgReg[`TASR_CFG_E3];
    assign cbitMode     = cfgReg[`TASR_CFG_CBIT];
    assign unipolarMode = cfgReg[`TASR_CFG_UNIPOLAR];

    // Counts the ones of a history window; the M window is zero-padded.
    function [4:0] countOnes;
        input [15:0] v;
        integer k;
        begin
            countOnes = 5'h00;
            for (k = 0; k < 16; k = k + 1) begin
                countOnes = countOnes + {4'h0, v[k]};
            end
        end
    endfunction

    // =================================================================
    // APB slave.
    // The read is captured, and its clear applied, on the edge that raises
    // pready, so an event at that edge lands in the latch after the
    // snapshot and is kept for the next read instead of being lost.
    assign addrOk      = (paddr[1:0] == 2'h0);
    assign hitStatus   = addrOk && (paddr[11:2] == `TASR_STATUS_IDX);
    assign hitMask     = addrOk && (paddr[11:2] == `TASR_MASK_IDX);
    assign hitConfig   = addrOk && (paddr[11:2] == `TASR_CONFIG_IDX);
    assign accessStart = psel && penable && !pready;
    assign statusRead  = accessStart && !pwrite && hitStatus;
    assign writeDone   = psel && penable && pready && pwrite && !pslverr;

    // Read data; unused upper bits read as zero.
    always @* begin
        rdMux = 32'h0000_0000;
        if (hitStatus) begin
            rdMux[6:0] = statusLatch;
        end else if (hitMask) begin
            rdMux[6:0] = maskReg;
        end else if (hitConfig) begin
            rdMux[2:0] = cfgReg;
        end
    end

    // One wait state on every access; unmapped addresses answer with pslverr.
    always @(posedge core_clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (accessStart) begin
            pready  <= 1'b1;
            pslverr <= !(hitStatus || hitMask || hitConfig);
            prdata  <= pwrite ? 32'h0000_0000 : rdMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writable registers; writes to the status word are ignored.
    always @(posedge core_clk) begin
        if (!rstn) begin
            maskReg <= `TASR_MASK_RST;
            cfgReg  <= `TASR_CFG_RST;
        end else if (writeDone) begin
            if (hitMask) begin
                maskReg <= pwdata[6:0];
            end
            if (hitConfig) begin
                cfgReg <= pwdata[2:0];
            end
        end
    end

    // =================================================================
    // T3 frame-loss detector.
    // History stops while frame is lost and restarts empty at resync, so
    // old errors cannot redeclare the loss the moment sync is regained.
    always @* begin
        next_fHist = fHist;
        next_mHist = mHist;
        if (fBitValid) begin
            next_fHist = {fHist[14:0], fBitError};
        end
        if (mBitValid) begin
            next_mHist = {mHist[2:0], mBitError};
        end
    end

    assign frameLossDeclare = (countOnes(next_fHist) >= `TASR_F_ERR_LIMIT) ||
                              (countOnes({12'h000, next_mHist}) >= `TASR_M_ERR_LIMIT);

    always @(posedge core_clk) begin
        if (!rstn || e3Mode) begin
            fHist       <= 16'h0000;
            mHist       <= 4'h0;
            frameLossT3 <= 1'b0;
        end else if (!frameLossT3) begin
            fHist       <= next_fHist;
            mHist       <= next_mHist;
            frameLossT3 <= frameLossDeclare;
        end else if (syncAcquired) begin
            fHist       <= 16'h0000;
            mHist       <= 4'h0;
            frameLossT3 <= 1'b0;
        end
    end

    // =================================================================
    // T3 remote-alarm detector on the per-multiframe X bits.
    always @(posedge core_clk) begin
        if (!rstn || e3Mode) begin
            zeroRun       <= 3'h0;
            oneRun        <= 3'h0;
            remoteAlarmT3 <= 1'b0;
        end else if (multiframeValid) begin
            if (!xBit1 && !xBit2) begin
                oneRun <= 3'h0;
                if (zeroRun != `TASR_X_RUN) begin
                    zeroRun <= zeroRun + 3'h1;
                end
                if (zeroRun == `TASR_X_RUN - 3'h1) begin
                    remoteAlarmT3 <= 1'b1;
                end
            end else if (xBit1 && xBit2) begin
                zeroRun <= 3'h0;
                if (oneRun != `TASR_X_RUN) begin
                    oneRun <= oneRun + 3'h1;
                end
                if (oneRun == `TASR_X_RUN - 3'h1) begin
                    remoteAlarmT3 <= 1'b0;
                end
            end else begin
                zeroRun <= 3'h0;
                oneRun  <= 3'h0;
            end
        end
    end

    // =================================================================
    // Pattern detectors: entry 0 is alarm indication, entry 1 is idle.
    // A field with a good pattern but non-zero C bits breaks both runs.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : gPattern
            reg [10:0] goodRun;
            reg [10:0] badRun;
            reg        detected;
            assign patternDet[i] = detected;
            always @(posedge core_clk) begin
                if (!rstn || e3Mode) begin
                    goodRun  <= 11'h000;
                    badRun   <= 11'h000;
                    detected <= 1'b0;
                end else if (fieldValid) begin
                    if (fieldPatternOk[i] && fieldCBitsZero[i]) begin
                        badRun <= 11'h000;
                        if (goodRun != `TASR_FIELD_RUN) begin
                            goodRun <= goodRun + 11'h001;
                        end
                        if (goodRun == `TASR_FIELD_RUN - 11'h001) begin
                            detected <= 1'b1;
                        end
                    end else if (!fieldPatternOk[i]) begin
                        goodRun <= 11'h000;
                        if (badRun != `TASR_FIELD_RUN) begin
                            badRun <= badRun + 11'h001;
                        end
                        if (badRun == `TASR_FIELD_RUN - 11'h001) begin
                            detected <= 1'b0;
                        end
                    end else begin
                        goodRun <= 11'h000;
                        badRun  <= 11'h000;
                    end
                end
            end
        end
    endgenerate

    // =================================================================
    // Alarm conditions per mode.
    // In E3 mode the idle condition is held at zero; software is expected to
    // disregard that bit there anyway.
    assign alarmCond[`TASR_BIT_SIGLOSS] = signalLossDetect && !unipolarMode;
    assign alarmCond[`TASR_BIT_FRMLOSS] = e3Mode ? e3FrameLoss : frameLossT3;
    assign alarmCond[`TASR_BIT_ALMIND]  = e3Mode ? e3AlarmInd : patternDet[0];
    assign alarmCond[`TASR_BIT_REMALM]  = e3Mode ? e3RemoteAlarm :
                                          (remoteAlarmT3 || (cbitMode && feacRemoteAlarm));
    assign alarmCond[`TASR_BIT_IDLE] = !e3Mode && patternDet[1];

    assign setVec   = {rxFrameBoundary, txFrameBoundary, alarmCond};
    assign causeVec = {rxFrameBoundary, txFrameBoundary, alarmCond ^ alarmPrev};

    // =================================================================
    // Latches and pending causes.
    // A set always wins over the read clear; a persisting alarm therefore
    // survives the read, which is exactly the clear-unless-present behaviour.
    always @* begin
        next_status  = setVec | (statusLatch & ~{7{statusRead}});
        next_pending = causeVec | (pending & ~{7{statusRead}});
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            statusLatch     <= `TASR_STATUS_RST;
            pending         <= 7'h00;
            alarmPrev       <= 5'h00;
            irqRequest      <= 1'b0;
            txFrameStartPin <= 1'b0;
            rxFrameStartPin <= 1'b0;
        end else begin
            statusLatch     <= next_status;
            pending         <= next_pending;
            alarmPrev       <= alarmCond;
            irqRequest      <= groupIrqEnable && (|(next_pending & maskReg));
            txFrameStartPin <= txFrameBoundary;
            rxFrameStartPin <= rxFrameBoundary;
        end
    end

endmodule

// ==== sim/tasr_props.sv ====
`timescale 1ns/100ps
// ==========
// Port-level checks of the status and mask block.
module tasr_props (
    input wire        core_clk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        signalLossDetect,
    input wire        txFrameBoundary,
    input wire        rxFrameBoundary,
    input wire        groupIrqEnable,
    input wire        txFrameStartPin,
    input wire        rxFrameStartPin,
    input wire        irqRequest
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Access cycle of a status read, before the answer.
    sequence statusRead;
        psel && penable && !pready && !pwrite && paddr == 12'h048;
    endsequence
    // Loss held long enough to fill the latch pipeline.
    sequence lossHeld;
        signalLossDetect [*2];
    endsequence
    // Each label guards one relation.
    tx_pin_a: assert property (txFrameBoundary |=> txFrameStartPin) else $error("tx pin missed");
    rx_pin_a: assert property (!rxFrameBoundary |=> !rxFrameStartPin) else $error("rx pin spurious");
    irq_gate_a: assert property (!groupIrqEnable |=> !irqRequest) else $error("irq not gated");
    loss_seen_a: assert property (lossHeld ##1 statusRead |=> prdata[0]) else $error("loss not read");
    unused_bits_a: assert property (pready && !pwrite && !pslverr |-> prdata[31:7] == 25'h0) else $error("unused set");
    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("bad wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready stuck");
    err_ready_a: assert property (pslverr |-> pready) else $error("lone slverr");
endmodule
bind tasr_alarm_status_irq tasr_props u_tasr_props (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .signalLossDetect, .txFrameBoundary, .rxFrameBoundary, .groupIrqEnable, .txFrameStartPin,
    .rxFrameStartPin, .irqRequest);

// ==== sim/tasr_framer_model.sv ====
`timescale 1ns/100ps
// ==========
// Framer stand-in: every detector strobe comes on one tick in eight cycles.
module tasr_framer_model (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire [2:0] cmd,
    input  wire       frmEn,
    output wire       signalLossDetect,
    output wire       fBitValid,
    output wire       fBitError,
    output wire       mBitValid,
    output wire       mBitError,
    output wire       syncAcquired,
    output wire       multiframeValid,
    output wire       xBit1,
    output wire       xBit2,
    output wire       fieldValid,
    output wire [1:0] fieldPatternOk,
    output wire [1:0] fieldCBitsZero,
    output wire       txFrameBoundary,
    output wire       rxFrameBoundary
);
    reg  [2:0] cnt;
    wire       tick = (cnt == 3'h7);
    // Divider restarts with reset so detector runs line up with the bench.
    always @(posedge core_clk) begin
        cnt <= rstn ? cnt + 3'h1 : 3'h0;
    end
    // Qualified data toggles between strobes, so no stale value looks valid.
    assign signalLossDetect = cmd[0];
    assign {fBitValid, mBitValid, multiframeValid, fieldValid} = {4{tick}};
    assign fBitError = tick ? cmd[1] : cnt[0];
    assign mBitError = fBitError;
    assign syncAcquired = tick & ~cmd[1];
    assign xBit1 = tick ? ~cmd[2] : cnt[0];
    assign xBit2 = xBit1;
    assign fieldPatternOk = tick ? 2'h0 : {2{cnt[0]}};
    assign fieldCBitsZero = tick ? 2'h3 : {2{cnt[1]}};
    assign txFrameBoundary = frmEn & tick;
    assign rxFrameBoundary = frmEn & (cnt == 3'h3);
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
// ==========
// Self-checking bench for the status and mask block.
module testbench;
    reg         core_clk = 1'b0;
    reg         rstn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [2:0]  cmd = 3'h0;
    reg         frmEn = 1'b0;
    reg         groupIrqEnable = 1'b0;
    reg         feac = 1'b0;
    reg  [2:0]  e3Alarms = 3'h0;
    reg  [31:0] rd, v;
    reg         er;
    wire [31:0] prdata;
    wire        pready, pslverr, txFrameStartPin, rxFrameStartPin, irqRequest, signalLossDetect, fBitValid;
    wire        fBitError, mBitValid, mBitError, syncAcquired, multiframeValid, xBit1, xBit2, fieldValid;
    wire        txFrameBoundary, rxFrameBoundary;
    wire [1:0]  fieldPatternOk, fieldCBitsZero;
    int         num_errors = 0, n_compared = 0, cyc = 0, i;

    always #10 core_clk = ~core_clk;

    tasr_framer_model u_tasr_framer_model (.core_clk, .rstn, .cmd, .frmEn, .signalLossDetect, .fBitValid,
        .fBitError, .mBitValid, .mBitError, .syncAcquired, .multiframeValid, .xBit1, .xBit2, .fieldValid,
        .fieldPatternOk, .fieldCBitsZero, .txFrameBoundary, .rxFrameBoundary);
    // Coded remote alarm and the E3 levels are driven by the bench for the mode tests.
    tasr_alarm_status_irq u_tasr_alarm_status_irq (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .signalLossDetect, .fBitValid, .fBitError, .mBitValid, .mBitError,
        .syncAcquired, .multiframeValid, .xBit1, .xBit2, .feacRemoteAlarm(feac), .fieldValid, .fieldPatternOk,
        .fieldCBitsZero, .e3FrameLoss(e3Alarms[0]), .e3AlarmInd(e3Alarms[1]), .e3RemoteAlarm(e3Alarms[2]),
        .txFrameBoundary,
        .rxFrameBoundary, .groupIrqEnable, .txFrameStartPin, .rxFrameStartPin, .irqRequest);

    task end_sim;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] e, input logic [31:0] s, input string nm);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One transfer; request held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Status word expected for loss, frame-loss and remote-alarm commands.
    function logic [31:0] stat(input logic [2:0] c);
        stat = {28'h0, c[2], 1'b0, c[1:0]};
    endfunction

    // A hung run is cut short and counted as a mismatch.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            end_sim;
        end
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        v = $urandom(32'he513);
        apb(0, 12'h050, 0); chk(0, rd, "mask reset");
        for (i = 0; i < 4; i++) begin
            v = $urandom;
            apb(1, 12'h050, v);
            apb(0, 12'h050, 0); chk({25'h0, v[6:0]}, rd, "mask");
            apb(0, {1'b1, v[10:2], 2'h0}, 0); chk(1, er, "slverr");
        end
        apb(1, 12'h048, 32'hFFFFFFFF);
        apb(0, 12'h048, 0);
        apb(0, 12'h048, 0); chk(0, rd, "status idle");
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            cmd <= 3'h1 << i;
            repeat (60) @(posedge core_clk);
            apb(0, 12'h048, 0); chk(stat(3'h1 << i), rd, "alarm set");
            apb(0, 12'h048, 0); chk(stat(3'h1 << i), rd, "alarm held");
            cmd <= 3'h0;
            repeat (60) @(posedge core_clk);
            apb(0, 12'h048, 0); chk(stat(3'h1 << i), rd, "alarm latched");
            apb(0, 12'h048, 0); chk(0, rd, "alarm cleared");
        end
        $display("test alarms done");
        frmEn <= 1'b1;
        repeat (20) @(posedge core_clk);
        frmEn <= 1'b0;
        apb(0, 12'h048, 0); chk(32'h60, rd, "frame set");
        apb(0, 12'h048, 0); chk(0, rd, "frame cleared");
        $display("test frames done");
        apb(1, 12'h050, 32'h1);
        groupIrqEnable <= 1'b1;
        cmd <= 3'h1;
        repeat (8) @(posedge core_clk);
        chk(1, irqRequest, "irq raise");
        apb(0, 12'h048, 0);
        repeat (2) @(posedge core_clk);
        chk(0, irqRequest, "irq release");
        groupIrqEnable <= 1'b0;
        cmd <= 3'h0;
        repeat (8) @(posedge core_clk);
        chk(0, irqRequest, "irq gated");
        apb(1, 12'h050, 32'h20);
        groupIrqEnable <= 1'b1;
        frmEn <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk(1, irqRequest, "irq frame");
        frmEn <= 1'b0;
        apb(0, 12'h048, 0);
        repeat (2) @(posedge core_clk);
        chk(0, irqRequest, "irq frame release");
        $display("test interrupts done");
        groupIrqEnable <= 1'b0;
        apb(1, 12'h040, 32'h2);
        apb(0, 12'h040, 0); chk(32'h2, rd, "config");
        feac <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(0, 12'h048, 0); chk(32'h8, rd, "coded remote alarm");
        feac <= 1'b0;
        repeat (2) @(posedge core_clk);
        apb(0, 12'h048, 0); chk(32'h8, rd, "coded latched");
        apb(1, 12'h040, 32'h1);
        e3Alarms <= 3'h7;
        repeat (4) @(posedge core_clk);
        // The idle bit is disregarded in E3 mode, as host software must.
        apb(0, 12'h048, 0); chk(32'hE, rd & ~32'h10, "e3 alarms");
        e3Alarms <= 3'h0;
        repeat (4) @(posedge core_clk);
        apb(0, 12'h048, 0); chk(32'hE, rd & ~32'h10, "e3 latched");
        apb(0, 12'h048, 0); chk(0, rd & ~32'h10, "e3 cleared");
        $display("test modes done");
        end_sim;
    end
endmodule
